// ---- host_port_pkg.sv ----
// shared constants and carrier types for the host control register port
package host_port_pkg;
    localparam int unsigned ADDR_WIDTH  = 8;
    localparam int unsigned DATA_WIDTH  = 8;
    localparam int unsigned REG_COUNT   = 256;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [7:0]  DATA_IDLE   = 8'h00;

    // host-side strobes after synchronisation, all active low
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] addr;
        logic [7:0] data;
    } host_bus_type;

    // drive side of the bidirectional data pin
    typedef struct packed {
        logic [7:0] dout;
        logic       doe;
    } data_pin_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } port_state_type;
endpackage

// ---- host_control_register_port.sv ----
// host control register port: asynchronous 8-bit memory-mapped register access
// Behaviour
// - drive data only when selected, reading, not writing
// - each register has unique flat 8-bit address
// - selected read places addressed register on bus
// - selected write loads bus value into register
// - read held low makes write a direction select
// - no access without chip select low
// - port runs unsynchronised to sample processing
`default_nettype none

// timing as the host sees it, counted in sys_clk edges
//   every pin passes two flops, so the port decides two edges after the
//   pins move and shows its answer one edge later, on the third
//   read: data_oe and data_out rise three edges after the strobes select
//   a read and fall three edges after they stop selecting it
//   write: the byte is committed as the write strobe or chip select rises,
//   three edges later, using the address and data seen at that rise;
//   write_pulse marks the commit for one cycle
//   both strobes low counts as a write and leaves data_oe low
//   with read held low and chip select held, the write strobe alone turns
//   the bus round; the byte just written is what the read then shows
// limitations the host must respect
//   strobes stand and rest for at least two edges each; a shorter glitch
//   may be missed outright
//   address and data stay put for two edges after a write strobe rises,
//   or a half-settled byte may be committed
//   nothing here is tied to the sample path, so new settings reach the
//   core at any moment; the host follows writes with its sync strobe
//   addresses at or above REGS read as zero and write nowhere
//   the tri-state driver sits outside this block, enabled by data_oe

module host_control_register_port
    import host_port_pkg::*;
#(
    parameter int unsigned REGS = REG_COUNT
)
(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // host pins
    input  wire logic                   cs_n,
    input  wire logic                   rd_n,
    input  wire logic                   wr_n,
    input  wire logic [ADDR_WIDTH-1:0]  addr,
    input  wire logic [DATA_WIDTH-1:0]  data_in,
    output logic      [DATA_WIDTH-1:0]  data_out,
    output logic                        data_oe,
    // register contents towards the tuner core
    output logic      [DATA_WIDTH*REGS-1:0] reg_bank,
    output logic                        write_pulse
);

    typedef struct packed {
        // two flop stages on every host pin; only s2 is decoded
        host_bus_type               s1;
        host_bus_type               s2;
        port_state_type             state;
        // the pin drive is registered so data_oe never glitches
        data_pin_type               pin;
        logic                       wr_pulse;
        logic [DATA_WIDTH*REGS-1:0] regs;
    } state_type;

    state_type r_q;
    state_type r_d;

    // pins at rest: strobes high, address and data low
    localparam host_bus_type BUS_IDLE = '{
        cs_n: 1'b1,
        rd_n: 1'b1,
        wr_n: 1'b1,
        addr: 8'h00,
        data: 8'h00
    };

    // chip select gates both directions of transfer
    function automatic logic wants_write(input host_bus_type b);
        wants_write = !b.cs_n && !b.wr_n;
    endfunction

    // a read needs the write strobe high, so both strobes low stays a write
    function automatic logic wants_read(input host_bus_type b);
        wants_read = !b.cs_n && !b.rd_n && b.wr_n;
    endfunction

    // an address past the bank reads as idle and writes nowhere, instead of
    // reaching outside the vector when REGS is set below the address space
    function automatic logic in_bank(input logic [ADDR_WIDTH-1:0] a);
        in_bank = 32'(a) < REGS;
    endfunction

    function automatic logic [DATA_WIDTH-1:0] reg_at(
        input logic [DATA_WIDTH*REGS-1:0] bank,
        input logic [ADDR_WIDTH-1:0]      a
    );
        reg_at = DATA_IDLE;
        if (in_bank(a))
        begin
            reg_at = bank[a*DATA_WIDTH +: DATA_WIDTH];
        end
    endfunction

    // the pins belong to the host's timing, so they pass two flops first;
    // this makes the port free-running beside the sample path
    always_comb
    begin
        r_d = r_q;
        r_d.s1.cs_n = cs_n;
        r_d.s1.rd_n = rd_n;
        r_d.s1.wr_n = wr_n;
        r_d.s1.addr = addr;
        r_d.s1.data = data_in;
        // only the second stage is decoded; the first may still be metastable
        r_d.s2 = r_q.s1;
        r_d.wr_pulse = 1'b0;
        r_d.pin.doe = 1'b0;
        r_d.pin.dout = DATA_IDLE;
        case (r_q.state)
            ST_IDLE:
            begin
                // a write outranks a read when both strobes are low
                if (wants_write(r_q.s2))
                begin
                    r_d.state = ST_WRITE;
                end
                else if (wants_read(r_q.s2))
                begin
                    r_d.state = ST_READ;
                    r_d.pin.doe = 1'b1;
                    r_d.pin.dout = reg_at(r_q.regs, r_q.s2.addr);
                end
                else
                begin
                    r_d.state = ST_IDLE;
                end
            end
            ST_READ:
            begin
                // bus released at once if any strobe drops away
                if (wants_read(r_q.s2))
                begin
                    r_d.pin.doe = 1'b1;
                    r_d.pin.dout = reg_at(r_q.regs, r_q.s2.addr);
                end
                else if (wants_write(r_q.s2))
                begin
                    r_d.state = ST_WRITE;
                end
                else
                begin
                    r_d.state = ST_IDLE;
                end
            end
            ST_WRITE:
            begin
                // the value is taken on the trailing edge of the strobe,
                // when host data has surely settled; address and data come
                // from the same stage as the strobe, so all three agree
                if (!wants_write(r_q.s2))
                begin
                    if (in_bank(r_q.s2.addr))
                    begin
                        r_d.regs[r_q.s2.addr*DATA_WIDTH +: DATA_WIDTH] = r_q.s2.data;
                    end
                    r_d.wr_pulse = 1'b1;
                    // with chip select held, the write strobe rising turns
                    // the bus round at once; the new byte is read back
                    if (wants_read(r_q.s2))
                    begin
                        r_d.state = ST_READ;
                        r_d.pin.doe = 1'b1;
                        r_d.pin.dout = reg_at(r_d.regs, r_q.s2.addr);
                    end
                    else
                    begin
                        r_d.state = ST_IDLE;
                    end
                end
            end
            default:
            begin
                r_d.state = ST_IDLE;
            end
        endcase
    end

    // the sync flops are cleared as well, so no strobe seen during reset
    // can be decoded on the first edges after it
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            r_q.s1 <= BUS_IDLE;
            r_q.s2 <= BUS_IDLE;
            r_q.state <= ST_IDLE;
            r_q.pin <= '{dout: DATA_IDLE, doe: 1'b0};
            r_q.wr_pulse <= 1'b0;
            r_q.regs <= {REGS{REG_RESET}};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // every output is a flop of the state copy, so none glitches
    assign data_out    = r_q.pin.dout;
    assign data_oe     = r_q.pin.doe;
    assign reg_bank    = r_q.regs;
    // core uses this to know a sync pulse is due from the host
    assign write_pulse = r_q.wr_pulse;

endmodule // host_control_register_port

`default_nettype wire

// ---- host_port_chk.sv ----
// pin-level assertions for the host register port
`default_nettype none
module host_port_chk import host_port_pkg::*; #(parameter int unsigned REGS = REG_COUNT) (
    input wire logic sys_clk, resetn, cs_n, rd_n, wr_n, data_oe, write_pulse,
    input wire logic [7:0] addr, data_out,
    input wire logic [8*REGS-1:0] reg_bank
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic rsel = !cs_n && !rd_n && wr_n;
    wire logic wsel = !cs_n && !wr_n;
    drive_gate_a: assert property (data_oe == $past(rsel, 3))
        else $error("bad oe");
    idle_zero_a: assert property (!data_oe |-> data_out == 8'h00)
        else $error("bad idle");
    read_data_a: assert property (data_oe |-> data_out == reg_bank[{addr, 3'h0} +: 8])
        else $error("bad read");
    trail_commit_a: assert property (write_pulse |-> $past(wsel, 4) && !$past(wsel, 3))
        else $error("bad commit");
    one_pulse_a: assert property (write_pulse |=> !write_pulse)
        else $error("long pulse");
    bank_hold_a: assert property ($changed(reg_bank) |-> write_pulse)
        else $error("stray write");
    cover property (rsel ##3 data_oe);
    cover property (write_pulse);
    cover property (write_pulse && data_oe);
    cover property (!cs_n && !rd_n && !wr_n);
endmodule // host_port_chk
bind host_control_register_port host_port_chk #(.REGS(REGS)) chk (.*);
`default_nettype wire

// ---- host_cpu_model.sv ----
// host processor model that drives the register port pins
`default_nettype none
module host_cpu_model (
    input  wire logic       sys_clk, data_oe, write_pulse,
    input  wire logic [7:0] data_out,
    output logic            cs_n, rd_n, wr_n,
    output logic      [7:0] addr, data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       h_oe = 1'h0;
    logic [7:0] h_d  = 8'h00;
    // released bus shows the inverse of the last byte, never a stale copy
    assign data_in = h_oe ? h_d : data_oe ? data_out : ~h_d;
    initial {cs_n, rd_n, wr_n, addr} = 11'h700;
    // the host owes one sync strobe for every committed write; it counts them
    int unsigned syncs = 0;
    always @(posedge sys_clk)
    begin
        if (write_pulse)
        begin
            syncs <= syncs + 1;
        end
    end
    // read held low and chip select held: the write strobe alone turns round
    task automatic turn(input logic [7:0] a, d, output logic [8:0] q);
        @(negedge sys_clk) {cs_n, rd_n, wr_n, addr, h_d, h_oe} = {3'h0, a, d, 1'h1};
        repeat (4) @(negedge sys_clk);
        wr_n = 1'h1;
        repeat (3) @(negedge sys_clk);
        h_oe = 1'h0;
        @(negedge sys_clk) q = {data_oe, data_out};
        cs_n = 1'h1;
        repeat (3) @(negedge sys_clk);
    endtask
    // m is {cs_n, rd_n, wr_n}; rd_n is left as set, so it may stay low
    task automatic xfer(input logic [2:0] m, input logic [7:0] a, d, output logic [8:0] q);
        @(negedge sys_clk) {cs_n, rd_n, wr_n, addr, h_d, h_oe} = {m, a, d, !m[0]};
        repeat (4) @(negedge sys_clk);
        q = {data_oe, data_out};
        {cs_n, wr_n} = 2'h3;
        // address and data held past release for the trailing-edge commit
        repeat (3) @(negedge sys_clk);
        h_oe = 1'h0;
    endtask
endmodule // host_cpu_model
`default_nettype wire

// ---- tb_host_control_register_port.sv ----
// self-checking bench for the host register port
`default_nettype none
module tb_host_control_register_port;
    timeunit 1ns;
    timeprecision 1ps;
    import host_port_pkg::*;
    logic sys_clk = 1'h0, resetn = 1'h0, cs_n, rd_n, wr_n, data_oe, write_pulse;
    logic [7:0] addr, data_in, data_out;
    logic [8*REG_COUNT-1:0] reg_bank;
    logic [8:0] q;
    int n_fail = 0, check_count = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    host_control_register_port uut (.*);
    host_cpu_model host (.*);
    task automatic cmp(input logic [8:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic t_rw; // both ends of the address space
        host.xfer(3'h2, 8'hff, 8'h69, q);
        host.xfer(3'h2, 8'h00, 8'h96, q);
        host.xfer(3'h1, 8'hff, 8'h00, q);
        cmp(q, 9'h169);
        host.xfer(3'h1, 8'h00, 8'h00, q);
        cmp(q, 9'h196);
        $display("t_rw done");
    endtask
    task automatic t_nocs; // strobes without chip select change nothing
        host.xfer(3'h6, 8'h00, 8'h11, q);
        host.xfer(3'h5, 8'h00, 8'h00, q);
        cmp(q, 9'h000);
        host.xfer(3'h1, 8'h00, 8'h00, q);
        cmp(q, 9'h196);
        cmp(9'(host.syncs), 9'h002);
        $display("t_nocs done");
    endtask
    task automatic t_mode; // read strobe low, write strobe picks direction
        host.xfer(3'h0, 8'h10, 8'ha5, q);
        cmp(q, 9'h000);
        host.xfer(3'h1, 8'h10, 8'h00, q);
        cmp(q, 9'h1a5);
        $display("t_mode done");
    endtask
    task automatic t_turn; // chip select held while the write strobe turns the bus
        host.turn(8'h20, 8'h3c, q);
        cmp(q, 9'h13c);
        host.xfer(3'h1, 8'h20, 8'h00, q);
        cmp(q, 9'h13c);
        cmp(9'(host.syncs), 9'h004);
        $display("t_turn done");
    endtask
    task automatic summarize;
        $display("%0d checks, %0d mismatches", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge sys_clk);
        resetn = 1'h1;
        t_rw;
        t_nocs;
        t_mode;
        t_turn;
        summarize;
    end
endmodule // tb_host_control_register_port
`default_nettype wire
